// *** dual_fan_monitor.sv ***
// Dual fan monitor: presence, fault pins, tach period count, AXI4-Lite.
// Assumes one 25 MHz clock; fan lines are asynchronous pins.
// Notes on behaviour
// - Installed bits select expected fans
// - Uninstalled fan events update status but not fail outputs
// - Fan 1 installed; fan 2 from strap
// - Software may rewrite both installed bits
// - Installed unmasked fault asserts both fail outputs
// - Status bit 2 follows inverted fault pin
// - Status bit 3 latches fault, write-zero clears
// - Action bit 5 makes fault pin open-drain
// - Detected fault drives pin low and holds
// - Presence low plugged; status bits 0, 1
// - Presence change signals; hot-plug sets bit 7
// - Period counted by oscillator gated counter
// - Init first edge, count to sixth edge
// - Fan 1 then fan 2, repeat forever
// - Uninstalled fan ends by overrange time-out
// - Config bits 7:6 pick oscillator rate
// - Count above limit flags fan failure
// - Count is f times 240 over rpm, pulses
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dual_fan_monitor import fan_mon_pkg::*; #(
  parameter int OSC_DIV = OSC_DIV_HI
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0] i_tach,
  input wire logic [1:0] i_fault_n,
  output logic [1:0] o_fault_n,
  output logic [1:0] o_fault_oe,
  input wire logic [1:0] i_present_n,
  input wire logic i_second_fan_strap,
  output logic o_int_n,
  output logic o_cascaded_fail_n,
  output logic [1:0] o_free_wheel_start
);
  // Register index from a byte address
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = 8'(a >> 2);
  endfunction

  // Oscillator enable for a select code
  function automatic logic osc_tick(input logic [1:0] sel, input logic lo,
                                    input logic mid, input logic hi);
    osc_tick = (sel == OSC_470) ? lo : (sel == OSC_940) ? mid : (sel == OSC_1880) ? hi : 1'b0;
  endfunction

  // Oscillator ticks
  osc_if osc();
  osc_divider #(.DIV(OSC_DIV)) u_div (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .o_osc(osc)
  );

  // Pin synchronisers: tach, fault, presence, strap
  logic [6:0] pin_lvl, pin_rise, pin_fall;
  logic pin_valid;
  pin_sync #(.N(7)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_pin({i_second_fan_strap, i_present_n, i_fault_n, i_tach}),
    .o_level(pin_lvl),
    .o_rise(pin_rise),
    .o_fall(pin_fall),
    .o_valid(pin_valid)
  );
  logic [1:0] tach_rise, fault_lvl_n, fault_fall, pres_lvl_n, plug_ev, unplug_ev;
  assign tach_rise = pin_rise[1:0];
  assign fault_lvl_n = pin_lvl[3:2];
  assign fault_fall = pin_fall[3:2];
  assign pres_lvl_n = pin_lvl[5:4];
  assign plug_ev = pin_fall[5:4]; // Link shorts to ground
  assign unplug_ev = pin_rise[5:4];

  // Software registers
  logic [7:0] mon_cfg_q;
  logic [1:0] inst_q; // Installed fans
  logic strap_done_q; // Strap taken once
  logic [1:0][7:0] act_q, cfg_q, lim_q, period_q;
  // Sticky status bits per fan
  logic [1:0] pres_chg_q, fault_lat_q, slow_q, hotplug_q, pin_drive_q;
  logic [1:0] fw_q; // Free-wheel start pulse
  logic int_n_q;

  // AXI write side holding stations
  logic aw_held_q, w_held_q, bvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q; // Byte lane 0 enabled
  logic [1:0] bresp_q;
  // AXI read side
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Write decode
  logic do_wr, wr, w_mapped, r_mapped;
  logic [7:0] widx, ridx, rd_val;
  logic we_mon, we_inst;
  logic [1:0] we_stat, we_act, we_cfg, we_lim;
  assign do_wr = aw_held_q & w_held_q & ~bvalid_q;
  assign wr = do_wr & w_lane_q;
  assign widx = idx_of(aw_addr_q);
  assign we_mon = wr & (widx == IDX_MON_CFG);
  assign we_inst = wr & (widx == IDX_INSTALLED);
  assign we_stat = {wr & (widx == IDX_STAT1), wr & (widx == IDX_STAT0)};
  assign we_act = {wr & (widx == IDX_ACT1), wr & (widx == IDX_ACT0)};
  assign we_cfg = {wr & (widx == IDX_CFG1), wr & (widx == IDX_CFG0)};
  assign we_lim = {wr & (widx == IDX_LIM1), wr & (widx == IDX_LIM0)};

  // Map membership, shared by both directions
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == IDX_MON_CFG) || (i == IDX_INSTALLED) || (i == IDX_STAT0) || (i == IDX_STAT1)
             || (i == IDX_ACT0) || (i == IDX_ACT1) || (i == IDX_CFG0) || (i == IDX_CFG1)
             || (i == IDX_CNT0) || (i == IDX_CNT1) || (i == IDX_LIM0) || (i == IDX_LIM1);
  endfunction
  assign w_mapped = is_mapped(widx);
  assign ridx = idx_of(i_araddr);
  assign r_mapped = is_mapped(ridx);

  // Status byte assembly
  logic [1:0][7:0] stat;
  always_comb begin
    for (int f = 0; f < 2; f++) begin
      stat[f] = 8'h00;
      stat[f][ST_PLUGGED] = ~pres_lvl_n[f];
      stat[f][ST_PRES_CHG] = pres_chg_q[f];
      stat[f][ST_FAULT_NOW] = ~fault_lvl_n[f];
      stat[f][ST_FAULT_LAT] = fault_lat_q[f];
      stat[f][ST_SLOW] = slow_q[f];
      stat[f][ST_HOTPLUG] = hotplug_q[f];
    end
  end

  // Write-zero clear masks for sticky bits
  logic [1:0] clr_pres, clr_fault, clr_slow, clr_hot;
  assign clr_pres = we_stat & {~w_data_q[ST_PRES_CHG], ~w_data_q[ST_PRES_CHG]};
  assign clr_fault = we_stat & {~w_data_q[ST_FAULT_LAT], ~w_data_q[ST_FAULT_LAT]};
  assign clr_slow = we_stat & {~w_data_q[ST_SLOW], ~w_data_q[ST_SLOW]};
  assign clr_hot = we_stat & {~w_data_q[ST_HOTPLUG], ~w_data_q[ST_HOTPLUG]};

  // Read mux
  assign rd_val = (ridx == IDX_MON_CFG) ? mon_cfg_q :
                  (ridx == IDX_INSTALLED) ? {6'h00, inst_q} :
                  (ridx == IDX_STAT0) ? stat[0] :
                  (ridx == IDX_STAT1) ? stat[1] :
                  (ridx == IDX_ACT0) ? act_q[0] :
                  (ridx == IDX_ACT1) ? act_q[1] :
                  (ridx == IDX_CFG0) ? cfg_q[0] :
                  (ridx == IDX_CFG1) ? cfg_q[1] :
                  (ridx == IDX_CNT0) ? period_q[0] :
                  (ridx == IDX_CNT1) ? period_q[1] :
                  (ridx == IDX_LIM0) ? lim_q[0] :
                  (ridx == IDX_LIM1) ? lim_q[1] : 8'h00;

  // Bus handshakes; one write and one read at a time
  assign o_awready = ~aw_held_q & ~bvalid_q;
  assign o_wready = ~w_held_q & ~bvalid_q;
  assign o_arready = ~rvalid_q;

  // Write channel stations and response
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= i_wdata[7:0];
        w_lane_q <= i_wstrb[0];
      end
      if (do_wr) begin
        // Unmapped writes are dropped with an error
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel, answer one cycle after address
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Plain control registers
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mon_cfg_q <= MON_CFG_RST;
      act_q <= {ACT_RST, ACT_RST};
      cfg_q <= {CFG_RST, CFG_RST};
      lim_q <= {LIM_RST, LIM_RST};
    end else begin
      if (we_mon) begin
        mon_cfg_q <= w_data_q;
      end
      for (int f = 0; f < 2; f++) begin
        if (we_act[f]) begin
          act_q[f] <= w_data_q;
        end
        if (we_cfg[f]) begin
          cfg_q[f] <= w_data_q;
        end
        if (we_lim[f]) begin
          lim_q[f] <= w_data_q;
        end
      end
    end
  end

  // Installed bits: constant at reset, strap caught once settled
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      inst_q <= INSTALLED_RST;
      strap_done_q <= 1'b0;
    end else if (we_inst) begin
      // Software write wins and supersedes a strap not yet taken
      inst_q <= w_data_q[1:0];
      strap_done_q <= 1'b1;
    end else if (pin_valid && !strap_done_q) begin
      inst_q[1] <= pin_lvl[6];
      strap_done_q <= 1'b1;
    end
  end

  // Measurement sequencer state
  meas_state_t st_q;
  logic fan_q; // Fan under measurement
  logic [7:0] cnt_q;
  logic [2:0] edge_q;
  logic mon_en, tick, rise, sat;
  logic [1:0] sel;
  assign mon_en = mon_cfg_q[MON_EN_BIT];
  assign sel = cfg_q[fan_q][CFG_OSC_LSB +: 2];
  assign tick = osc_tick(sel, osc.tick_lo, osc.tick_mid, osc.tick_hi);
  assign rise = tach_rise[fan_q];
  assign sat = tick & (cnt_q == CNT_MAX);

  // Period measurement of each fan in turn
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= M_IDLE;
      fan_q <= 1'b0;
      cnt_q <= 8'h00;
      edge_q <= 3'h0;
      period_q <= {8'h00, 8'h00};
    end else if (!mon_en) begin
      st_q <= M_IDLE;
      fan_q <= 1'b0;
    end else begin
      case (st_q)
        M_IDLE: begin
          st_q <= M_ARM;
          fan_q <= 1'b0;
          cnt_q <= 8'h00;
        end
        M_ARM: begin
          if (sel == OSC_OFF) begin
            fan_q <= ~fan_q;
          end else if (sat) begin
            st_q <= M_STORE;
          end else if (rise) begin
            st_q <= M_START;
            cnt_q <= 8'h00;
          end else if (tick) begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        M_START: begin
          if (sat) begin
            st_q <= M_STORE;
          end else if (rise) begin
            st_q <= M_COUNT;
            cnt_q <= 8'h00;
            edge_q <= 3'h0;
          end else if (tick) begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        M_COUNT: begin
          // Oscillator gated into counter over four periods
          if (rise && edge_q == LAST_EDGE) begin
            st_q <= M_STORE;
          end else begin
            if (rise) begin
              edge_q <= edge_q + 3'h1;
            end
            if (sat) begin
              st_q <= M_STORE;
            end else if (tick) begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
        end
        M_STORE: begin
          period_q[fan_q] <= cnt_q;
          fan_q <= ~fan_q;
          cnt_q <= 8'h00;
          st_q <= M_ARM;
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // Slow fan detection at store time
  logic [1:0] slow_set;
  assign slow_set[0] = (st_q == M_STORE) & ~fan_q & (cnt_q > lim_q[0]);
  assign slow_set[1] = (st_q == M_STORE) & fan_q & (cnt_q > lim_q[1]);

  // Sticky status bits; a set in the clearing cycle wins
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pres_chg_q <= 2'h0;
      fault_lat_q <= 2'h0;
      slow_q <= 2'h0;
      hotplug_q <= 2'h0;
      fw_q <= 2'h0;
    end else begin
      pres_chg_q <= (pres_chg_q & ~clr_pres) | plug_ev | unplug_ev;
      fault_lat_q <= (fault_lat_q & ~clr_fault) | fault_fall;
      slow_q <= (slow_q & ~clr_slow) | slow_set;
      hotplug_q <= (hotplug_q & ~clr_hot) | plug_ev;
      fw_q <= plug_ev;
    end
  end

  // Fault pin drive: latched low until released by software
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_drive_q <= 2'h0;
    end else begin
      for (int f = 0; f < 2; f++) begin
        if (act_q[f][ACT_PIN_OUT] && fault_fall[f]) begin
          pin_drive_q[f] <= 1'b1;
        end else if (!act_q[f][ACT_PIN_OUT] || clr_fault[f]) begin
          pin_drive_q[f] <= 1'b0;
        end
      end
    end
  end

  // Events gated by installed bits and masks
  logic [1:0] ev;
  always_comb begin
    for (int f = 0; f < 2; f++) begin
      ev[f] = inst_q[f] & ((fault_lat_q[f] & ~act_q[f][ACT_MASK_FAULT])
            | ((pres_chg_q[f] | hotplug_q[f]) & ~act_q[f][ACT_MASK_SWAP])
            | (slow_q[f] & ~act_q[f][ACT_MASK_SLOW]));
    end
  end

  // Both fail outputs follow the gated events
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~|ev;
    end
  end

  assign o_int_n = int_n_q;
  assign o_cascaded_fail_n = int_n_q;
  assign o_fault_n = 2'h0; // Open drain: only ever pulls low
  assign o_fault_oe = pin_drive_q;
  assign o_free_wheel_start = fw_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
endmodule
`default_nettype wire

// *** fan_mon_pkg.sv ***
// Constants, register indices and types of the dual fan monitor.
// Assumes one 25 MHz system clock; shared by the monitor and the pin synchroniser.
`default_nettype none
package fan_mon_pkg;
  // System clock and on-chip tach oscillator rates
  localparam int CLK_HZ = 25_000_000;
  localparam int OSC_HI_HZ = 1880;
  localparam int OSC_DIV_HI = CLK_HZ / OSC_HI_HZ;
  localparam int ADDR_W = 9;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MON_CFG = 8'h01;
  localparam logic [7:0] IDX_INSTALLED = 8'h03;
  localparam logic [7:0] IDX_STAT0 = 8'h10;
  localparam logic [7:0] IDX_STAT1 = 8'h11;
  localparam logic [7:0] IDX_ACT0 = 8'h18;
  localparam logic [7:0] IDX_ACT1 = 8'h19;
  localparam logic [7:0] IDX_CFG0 = 8'h68;
  localparam logic [7:0] IDX_CFG1 = 8'h69;
  localparam logic [7:0] IDX_CNT0 = 8'h70;
  localparam logic [7:0] IDX_CNT1 = 8'h71;
  localparam logic [7:0] IDX_LIM0 = 8'h78;
  localparam logic [7:0] IDX_LIM1 = 8'h79;
  // Field positions
  localparam int MON_EN_BIT = 4;
  localparam int ST_PLUGGED = 0;
  localparam int ST_PRES_CHG = 1;
  localparam int ST_FAULT_NOW = 2;
  localparam int ST_FAULT_LAT = 3;
  localparam int ST_SLOW = 4;
  localparam int ST_HOTPLUG = 7;
  localparam int ACT_MASK_FAULT = 0;
  localparam int ACT_MASK_SWAP = 1;
  localparam int ACT_MASK_SLOW = 2;
  localparam int ACT_PIN_OUT = 5;
  localparam int CFG_OSC_LSB = 6;
  // Oscillator select codes
  localparam logic [1:0] OSC_OFF = 2'h0;
  localparam logic [1:0] OSC_470 = 2'h1;
  localparam logic [1:0] OSC_940 = 2'h2;
  localparam logic [1:0] OSC_1880 = 2'h3;
  // Reset values and counts
  localparam logic [1:0] INSTALLED_RST = 2'h1;
  localparam logic [7:0] MON_CFG_RST = 8'h00;
  localparam logic [7:0] ACT_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h40;
  localparam logic [7:0] LIM_RST = 8'hBF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [2:0] LAST_EDGE = 3'h3;
  localparam logic [1:0] SYNC_FILL = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Measurement sequencer, Gray along the usual path
  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_ARM = 3'h1,
    M_START = 3'h3,
    M_COUNT = 3'h7,
    M_STORE = 3'h5
  } meas_state_t;
endpackage
`default_nettype wire

// *** osc_if.sv ***
// Oscillator tick bundle from the divider to the monitor.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface osc_if;
  logic tick_hi; // 1880 Hz enable
  logic tick_mid; // 940 Hz enable
  logic tick_lo; // 470 Hz enable
  modport src(output tick_hi, output tick_mid, output tick_lo);
  modport dst(input tick_hi, input tick_mid, input tick_lo);
endinterface
`default_nettype wire

// *** osc_divider.sv ***
// Divider making the three tach oscillator enables.
// Assumes a free-running system clock; ticks are one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module osc_divider #(
  parameter int DIV = 13297
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  osc_if.src o_osc
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q; // Base divider
  logic [1:0] sub_q; // Halving stages
  logic hi_q, mid_q, lo_q;
  logic wrap;
  assign wrap = (cnt_q == CW'(DIV - 1));
  // Base rate, then halved twice so all rates stay phase-locked
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
      sub_q <= 2'h0;
      hi_q <= 1'b0;
      mid_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      if (wrap) begin
        sub_q <= sub_q + 2'h1;
      end
      hi_q <= wrap;
      mid_q <= wrap & sub_q[0];
      lo_q <= wrap & (&sub_q);
    end
  end
  assign o_osc.tick_hi = hi_q;
  assign o_osc.tick_mid = mid_q;
  assign o_osc.tick_lo = lo_q;
endmodule
`default_nettype wire

// *** pin_sync.sv ***
// Three-stage pin synchroniser with settled level and edge pulses.
// Assumes asynchronous pins; edges are suppressed until filled.
`timescale 1ns/1ps
`default_nettype none
module pin_sync import fan_mon_pkg::*; #(
  parameter int N = 7
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [N-1:0] i_pin,
  output logic [N-1:0] o_level,
  output logic [N-1:0] o_rise,
  output logic [N-1:0] o_fall,
  output logic o_valid
);
  logic [N-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_q, fall_q;
  logic [1:0] fill_q; // Cycles since reset
  logic agree_ok;
  assign agree_ok = (fill_q == SYNC_FILL);
  // A bit moves only when stages two and three agree
  assign lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      lvl_q <= '1;
      rise_q <= '0;
      fall_q <= '0;
      fill_q <= 2'h0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (!agree_ok) begin
        fill_q <= fill_q + 2'h1;
      end
      lvl_q <= agree_ok ? lvl_d : s2_q; // Stage two while filling, so no false edge after reset
      rise_q <= agree_ok ? (lvl_d & ~lvl_q) : '0;
      fall_q <= agree_ok ? (~lvl_d & lvl_q) : '0;
    end
  end
  assign o_level = lvl_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;
  assign o_valid = agree_ok;
endmodule
`default_nettype wire

// *** fan_mon_props.sv ***
// Port checker for the dual fan monitor.
// Assumes one clock; bound to each monitor instance.
`timescale 1ns/1ps
`default_nettype none
module fan_mon_props (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0] o_rresp,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_fault_n,
  input wire logic [1:0] o_fault_oe,
  input wire logic o_int_n,
  input wire logic o_cascaded_fail_n,
  input wire logic [1:0] o_free_wheel_start
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Both fail outputs share one event summary
  fail_pair_a: assert property (o_int_n == o_cascaded_fail_n) else $error("fail outputs differ");
  // Pin only ever pulled low
  pull_low_a: assert property ((o_fault_oe & o_fault_n) == 2'h0) else $error("fault pin driven high");
  // Latched pull holds until a register write lands
  pull_hold_a: assert property (o_fault_oe[0] && !o_bvalid |=> o_fault_oe[0] || o_bvalid)
    else $error("fault pull dropped");
  // Start pulse is one cycle wide
  start_pulse_a: assert property ((o_free_wheel_start & $past(o_free_wheel_start)) == 2'h0)
    else $error("start pulse too long");
  // Write answer stands until taken
  wr_resp_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped");
  // Read answer stands until taken
  rd_resp_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read answer dropped");
  // No new write while an answer is pending
  wr_block_a: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write not blocked");
  // No new read while data is pending; registers are 8 bits
  rd_block_a: assert property (o_rvalid |-> !o_arready && o_rdata[31:8] == 24'h0)
    else $error("read not blocked");
  hot_plug_c: cover property (o_free_wheel_start[1]);
  pull_c: cover property ($rose(o_fault_oe[0]));
  bad_addr_c: cover property (o_rvalid && o_rresp == 2'h2);
endmodule
bind dual_fan_monitor fan_mon_props chk_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .o_awready(o_awready), .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_rresp(o_rresp), .o_rdata(o_rdata), .o_fault_n(o_fault_n), .o_fault_oe(o_fault_oe),
  .o_int_n(o_int_n), .o_cascaded_fail_n(o_cascaded_fail_n), .o_free_wheel_start(o_free_wheel_start));
`default_nettype wire

// *** fan_partner.sv ***
// Fan connector model: tach, open-drain fault, presence link.
// Assumes the bench calls its tasks; fan 2 tach stands still.
`timescale 1ns/1ps
`default_nettype none
module fan_partner (
  output logic [1:0] o_tach,
  output logic [1:0] o_fault_n,
  output logic [1:0] o_present_n
);
  // Fan 1 spins with a 4000 ns tach period
  initial begin
    o_tach = 2'h0;
    o_fault_n = 2'h3;
    o_present_n = 2'h0;
    forever #2000 o_tach[0] = ~o_tach[0];
  end
  // Only pulls low or lets go to the pull-up
  task automatic fault(input int i, input logic v);
    o_fault_n[i] = v;
  endtask
  // Link to ground means plugged
  task automatic plug(input int i, input logic v);
    o_present_n[i] = v;
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the dual fan monitor.
// Assumes the fan model drives the connector lines.
`timescale 1ns/1ps
`default_nettype none
module testbench import fan_mon_pkg::*;;
  typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic [1:0] rs;} exp_t;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic strap = 1'h1;
  logic [ADDR_W-1:0] awaddr = 9'h0, araddr = 9'h0;
  logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awr, wrr, bv, arr, rv, intn, cfn;
  logic [1:0] bresp, rresp, tach, fan_n, pres_n, oe, dut_n, fw, r;
  wire [1:0] flt_wire = fan_n & ~(oe & ~dut_n); // Open-drain line with pull-up
  exp_t q[$];
  exp_t e;
  int errors = 0, total_checks = 0, cyc = 0, fwc = 0, x;
  dual_fan_monitor #(.OSC_DIV(4)) dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wv),
    .o_wready(wrr), .o_bresp(bresp), .o_bvalid(bv), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
    .i_rready(rready), .i_tach(tach), .i_fault_n(flt_wire), .o_fault_n(dut_n), .o_fault_oe(oe),
    .i_present_n(pres_n), .i_second_fan_strap(strap), .o_int_n(intn),
    .o_cascaded_fail_n(cfn), .o_free_wheel_start(fw));
  fan_partner fan_u (.o_tach(tach), .o_fault_n(fan_n), .o_present_n(pres_n));
  initial forever #20 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
  // Read monitor, settled values at the falling edge
  always @(negedge clk) begin
    if (fw[1]) fwc++;
    if (rv && rready && q.size() > 0) begin
      e = q.pop_front();
      check({30'h0, rresp}, {30'h0, e.rs});
      check({31'h0, rdata >= e.lo && rdata <= e.hi}, 32'h1);
    end
  end
  // Ends half a cycle past the edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Write: both channels offered together, random answer stall
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic da, dw, ta, tw;
    da = 1'h0;
    dw = 1'h0;
    @(posedge clk);
    awaddr <= {i[6:0], 2'h0};
    wdata <= ($urandom << 8) | {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    do begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wrr;
      @(posedge clk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      da |= ta;
      dw |= tw;
    end while (!(da && dw));
    repeat ($urandom % 2) @(posedge clk);
    bready <= 1'h1;
    do @(negedge clk); while (!(bv && bready));
    r = bresp;
    @(posedge clk);
    bready <= 1'h0;
  endtask
  // Read: expected range noted before the request
  task automatic rd(input logic [7:0] i, input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] rs);
    q.push_back({lo, hi, rs});
    @(posedge clk);
    araddr <= {i[6:0], 2'h0};
    arv <= 1'h1;
    do @(negedge clk); while (!(arv && arr));
    @(posedge clk);
    arv <= 1'h0;
    repeat ($urandom % 2) @(posedge clk);
    rready <= 1'h1;
    do @(negedge clk); while (!(rv && rready));
    @(posedge clk);
    rready <= 1'h0;
  endtask
  initial begin
    x = $urandom(32'h0274);
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    tick(8);
    rd(IDX_INSTALLED, 8'h03, 8'h03, RESP_OKAY);
    rd(IDX_CFG0, CFG_RST, CFG_RST, RESP_OKAY);
    rd(IDX_LIM0, LIM_RST, LIM_RST, RESP_OKAY);
    rd(IDX_STAT0, 8'h01, 8'h01, RESP_OKAY);
    rd(8'h50, 8'h00, 8'h00, RESP_SLVERR);
    wr(8'h50, 8'h11);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(IDX_CNT0, 8'h33);
    rd(IDX_CNT0, 8'h00, 8'h00, RESP_OKAY);
    x = $urandom % 256;
    wr(IDX_LIM1, x[7:0]);
    rd(IDX_LIM1, x[7:0], x[7:0], RESP_OKAY);
    $display("register test done");
    fan_u.plug(1, 1'h1);
    tick(10);
    check({31'h0, intn}, 32'h0);
    rd(IDX_STAT1, 8'h02, 8'h02, RESP_OKAY);
    wr(IDX_STAT1, 8'h00);
    tick(4);
    check({31'h0, intn}, 32'h1);
    fan_u.plug(1, 1'h0);
    tick(10);
    check(fwc, 32'h1);
    rd(IDX_STAT1, 8'h83, 8'h83, RESP_OKAY);
    wr(IDX_STAT1, 8'h00);
    $display("presence test done");
    wr(IDX_INSTALLED, 8'h01);
    fan_u.fault(1, 1'h0);
    tick(10);
    check({31'h0, intn}, 32'h1);
    rd(IDX_STAT1, 8'h0D, 8'h0D, RESP_OKAY);
    fan_u.fault(1, 1'h1);
    tick(10);
    rd(IDX_STAT1, 8'h09, 8'h09, RESP_OKAY);
    wr(IDX_STAT1, 8'h00);
    rd(IDX_STAT1, 8'h01, 8'h01, RESP_OKAY);
    wr(IDX_ACT0, 8'h20);
    fan_u.fault(0, 1'h0);
    tick(10);
    check({30'h0, intn, cfn}, 32'h0);
    fan_u.fault(0, 1'h1);
    tick(10);
    check({29'h0, oe, flt_wire[0]}, 32'h2);
    rd(IDX_STAT0, 8'h0D, 8'h0D, RESP_OKAY);
    wr(IDX_STAT0, 8'h00);
    tick(10);
    check({29'h0, oe, intn}, 32'h1);
    wr(IDX_ACT0, 8'h01);
    fan_u.fault(0, 1'h0);
    tick(10);
    check({31'h0, intn}, 32'h1);
    fan_u.fault(0, 1'h1);
    wr(IDX_STAT0, 8'h00);
    $display("fault test done");
    wr(IDX_CFG1, 8'hC0);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MON_CFG, 8'h00);
      wr(IDX_CFG0, {c[1:0], 6'h00});
      wr(IDX_MON_CFG, 8'h10);
      tick((c == 0 ? 0 : 384 * (4 << (3 - c))) + 1536 + 400);
      x = c == 0 ? 0 : 100 >> (3 - c);
      rd(IDX_CNT0, 8'(x - (c > 0) * 2), 8'(x + (c > 0) * 2), RESP_OKAY);
    end
    rd(IDX_CNT1, CNT_MAX, CNT_MAX, RESP_OKAY);
    rd(IDX_STAT0, 8'h01, 8'h01, RESP_OKAY);
    wr(IDX_LIM0, 8'h5F);
    tick(2400);
    rd(IDX_STAT0, 8'h11, 8'h11, RESP_OKAY);
    $display("measure test done");
    tick(4);
    conclude();
  end
endmodule
`default_nettype wire
